/* File: rtl/xcvr_dir_pkg.sv */
// Constants and enumerations for the instrument-bus transceiver direction block
// What this block does
// - Data buffers follow chip data direction enable
// - Clear, remote, attention buffers always receive
// - Service request buffer always sends outward
// - End and handshake buffers follow handshake enable
// - Talker: data buffers outward, bus data blocked
// - Transceiver enables are active low
// - Serial poll holds data-valid path low
// - Talker drives data, end, data-valid outward
package xcvr_dir_pkg;
    localparam int unsigned DATA_WIDTH = 8;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic ENABLE_ON = 1'b0;
    localparam logic ENABLE_OFF = 1'b1;
    typedef enum logic [2:0] {
        DIR_IDLE = 3'b001,
        DIR_LISTEN = 3'b010,
        DIR_TALK = 3'b100
    } hs_dir_e;
endpackage

/* File: rtl/pin_sync.sv */
// Two-stage synchroniser for a group of pin inputs
module pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    always_comb
    begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule // pin_sync

/* File: rtl/xcvr_dir.sv */
// Direction control for the instrument-bus transceivers
module xcvr_dir
    import xcvr_dir_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Interface chip side
    input wire logic data_line_direction_enable,
    input wire logic handshake_direction_enable,
    input wire logic serial_poll_hold,
    input wire logic [xcvr_dir_pkg::DATA_WIDTH-1:0] chip_data_out,
    output logic [xcvr_dir_pkg::DATA_WIDTH-1:0] chip_data_in,
    input wire logic chip_eoi_out,
    input wire logic chip_dav_out,
    input wire logic chip_nrfd_out,
    input wire logic chip_ndac_out,
    input wire logic chip_srq_out,
    output logic chip_eoi_in,
    output logic chip_dav_in,
    output logic chip_nrfd_in,
    output logic chip_ndac_in,
    output logic chip_ifc_in,
    output logic chip_ren_in,
    output logic chip_atn_in,
    // Bus data lines
    input wire logic [xcvr_dir_pkg::DATA_WIDTH-1:0] bus_data_i,
    output logic [xcvr_dir_pkg::DATA_WIDTH-1:0] bus_data_o,
    output logic bus_data_oe_n,
    // Bus handshake and end lines
    input wire logic bus_eoi_i,
    input wire logic bus_dav_i,
    input wire logic bus_nrfd_i,
    input wire logic bus_ndac_i,
    output logic bus_eoi_o,
    output logic bus_dav_o,
    output logic bus_nrfd_o,
    output logic bus_ndac_o,
    output logic bus_talk_oe_n,
    output logic bus_listen_oe_n,
    // Bus receive-only and send-only lines
    input wire logic bus_ifc_i,
    input wire logic bus_ren_i,
    input wire logic bus_atn_i,
    output logic bus_srq_o,
    output logic bus_srq_oe_n
);
    import xcvr_dir_pkg::*;

    localparam int unsigned NSYNC = DATA_WIDTH + 7;

    logic [NSYNC-1:0] pins_sync;
    logic [DATA_WIDTH-1:0] s_data;
    logic s_eoi, s_dav, s_nrfd, s_ndac, s_ifc, s_ren, s_atn;

    // Bus pins come from another domain
    pin_sync #(
        .WIDTH(NSYNC)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .async_in({bus_data_i, bus_eoi_i, bus_dav_i, bus_nrfd_i, bus_ndac_i,
                   bus_ifc_i, bus_ren_i, bus_atn_i}),
        .sync_out(pins_sync)
    );
    assign {s_data, s_eoi, s_dav, s_nrfd, s_ndac, s_ifc, s_ren, s_atn} = pins_sync;

    hs_dir_e dir_reg, dir_next;
    logic data_oe_n_reg, data_oe_n_next;
    logic [DATA_WIDTH-1:0] data_o_reg, data_o_next;
    logic [DATA_WIDTH-1:0] data_in_reg, data_in_next;
    logic eoi_o_reg, eoi_o_next, dav_o_reg, dav_o_next;
    logic nrfd_o_reg, nrfd_o_next, ndac_o_reg, ndac_o_next;
    logic eoi_in_reg, eoi_in_next, dav_in_reg, dav_in_next;
    logic nrfd_in_reg, nrfd_in_next, ndac_in_reg, ndac_in_next;
    logic ifc_reg, ifc_next, ren_reg, ren_next, atn_reg, atn_next;
    logic srq_reg, srq_next;

    always_comb
    begin
        dir_next = handshake_direction_enable ? DIR_TALK : DIR_LISTEN;
        data_oe_n_next = data_line_direction_enable ? ENABLE_ON : ENABLE_OFF;
        data_o_next = chip_data_out;
        data_in_next = data_line_direction_enable ? data_in_reg : s_data;
        eoi_o_next = chip_eoi_out;
        // serial poll holds valid path low
        dav_o_next = serial_poll_hold ? 1'b0 : chip_dav_out;
        nrfd_o_next = chip_nrfd_out;
        ndac_o_next = chip_ndac_out;
        // end and data-valid pass only in listen direction; ready and accepted pass only in talk direction
        eoi_in_next = handshake_direction_enable ? eoi_in_reg : s_eoi;
        dav_in_next = handshake_direction_enable ? dav_in_reg : s_dav;
        nrfd_in_next = handshake_direction_enable ? s_nrfd : nrfd_in_reg;
        ndac_in_next = handshake_direction_enable ? s_ndac : ndac_in_reg;
        ifc_next = s_ifc;
        ren_next = s_ren;
        atn_next = s_atn;
        srq_next = chip_srq_out;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            dir_reg <= DIR_IDLE;
            data_oe_n_reg <= ENABLE_OFF;
            data_o_reg <= DATA_RESET;
            data_in_reg <= DATA_RESET;
            eoi_o_reg <= 1'b0;
            dav_o_reg <= 1'b0;
            nrfd_o_reg <= 1'b0;
            ndac_o_reg <= 1'b0;
            eoi_in_reg <= 1'b0;
            dav_in_reg <= 1'b0;
            nrfd_in_reg <= 1'b0;
            ndac_in_reg <= 1'b0;
            ifc_reg <= 1'b0;
            ren_reg <= 1'b0;
            atn_reg <= 1'b0;
            srq_reg <= 1'b0;
        end
        else
        begin
            dir_reg <= dir_next;
            data_oe_n_reg <= data_oe_n_next;
            data_o_reg <= data_o_next;
            data_in_reg <= data_in_next;
            eoi_o_reg <= eoi_o_next;
            dav_o_reg <= dav_o_next;
            nrfd_o_reg <= nrfd_o_next;
            ndac_o_reg <= ndac_o_next;
            eoi_in_reg <= eoi_in_next;
            dav_in_reg <= dav_in_next;
            nrfd_in_reg <= nrfd_in_next;
            ndac_in_reg <= ndac_in_next;
            ifc_reg <= ifc_next;
            ren_reg <= ren_next;
            atn_reg <= atn_next;
            srq_reg <= srq_next;
        end
    end

    assign bus_data_oe_n = data_oe_n_reg;
    assign bus_talk_oe_n = (dir_reg == DIR_TALK) ? ENABLE_ON : ENABLE_OFF;
    // listener group only when not talking
    assign bus_listen_oe_n = (dir_reg == DIR_LISTEN) ? ENABLE_ON : ENABLE_OFF;
    assign bus_srq_oe_n = ENABLE_ON;
    assign bus_data_o = data_o_reg;
    assign bus_eoi_o = eoi_o_reg;
    assign bus_dav_o = dav_o_reg;
    assign bus_nrfd_o = nrfd_o_reg;
    assign bus_ndac_o = ndac_o_reg;
    assign bus_srq_o = srq_reg;
    assign chip_data_in = data_in_reg;
    assign chip_eoi_in = eoi_in_reg;
    assign chip_dav_in = dav_in_reg;
    assign chip_nrfd_in = nrfd_in_reg;
    assign chip_ndac_in = ndac_in_reg;
    assign chip_ifc_in = ifc_reg;
    assign chip_ren_in = ren_reg;
    assign chip_atn_in = atn_reg;

    a_data_dir: assert property (@(posedge clk) disable iff (rst)
        data_line_direction_enable |=> (bus_data_oe_n == ENABLE_ON))
        else $error("data buffers not outward after direction enable");
    a_data_recv: assert property (@(posedge clk) disable iff (rst)
        !data_line_direction_enable |=> (bus_data_oe_n == ENABLE_OFF))
        else $error("data buffers driving while receive selected");
    a_srq_out: assert property (@(posedge clk) disable iff (rst)
        bus_srq_oe_n == ENABLE_ON ##1 bus_srq_o == $past(chip_srq_out))
        else $error("service request not passed outward");
    a_talk_block: assert property (@(posedge clk) disable iff (rst)
        data_line_direction_enable |=> $stable(chip_data_in))
        else $error("bus data reached chip while talking");
    a_hs_exclusive: assert property (@(posedge clk) disable iff (rst)
        !(bus_talk_oe_n == ENABLE_ON && bus_listen_oe_n == ENABLE_ON))
        else $error("both handshake groups driven");
    a_hs_dir: assert property (@(posedge clk) disable iff (rst)
        handshake_direction_enable |=> bus_talk_oe_n == ENABLE_ON)
        else $error("talk group not enabled");
    a_poll_hold: assert property (@(posedge clk) disable iff (rst)
        serial_poll_hold |=> !bus_dav_o)
        else $error("data valid not held low in serial poll");
    a_recv_only: assert property (@(posedge clk) disable iff (rst)
        $rose(bus_atn_i) |-> ##3 chip_atn_in)
        else $error("attention not received within three cycles");
    a_talk_drive: assert property (@(posedge clk) disable iff (rst)
        (handshake_direction_enable && !serial_poll_hold) |=> bus_dav_o == $past(chip_dav_out))
        else $error("talker data valid not driven");
    a_talk_freeze: assert property (@(posedge clk) disable iff (rst)
        handshake_direction_enable |=> ($stable(chip_eoi_in) && $stable(chip_dav_in)))
        else $error("bus end or data valid reached chip while talking");
    a_listen_freeze: assert property (@(posedge clk) disable iff (rst)
        !handshake_direction_enable |=> ($stable(chip_nrfd_in) && $stable(chip_ndac_in)))
        else $error("bus ready or accepted reached chip while listening");
    a_listen_dir: assert property (@(posedge clk) disable iff (rst)
        !handshake_direction_enable |=> (bus_listen_oe_n == ENABLE_ON))
        else $error("listen group not enabled");
    a_data_drive: assert property (@(posedge clk) disable iff (rst)
        data_line_direction_enable |=> (bus_data_o == $past(chip_data_out)))
        else $error("talker data not driven outward");
    a_ifc_recv: assert property (@(posedge clk) disable iff (rst)
        $rose(bus_ifc_i) |-> ##3 chip_ifc_in)
        else $error("interface clear not received within three cycles");
    c_talk: cover property (@(posedge clk) disable iff (rst)
        bus_talk_oe_n == ENABLE_ON && bus_data_oe_n == ENABLE_ON);
    c_listen: cover property (@(posedge clk) disable iff (rst)
        bus_listen_oe_n == ENABLE_ON && bus_data_oe_n == ENABLE_OFF);
    c_poll: cover property (@(posedge clk) disable iff (rst)
        serial_poll_hold ##1 !serial_poll_hold);
    c_srq: cover property (@(posedge clk) disable iff (rst)
        bus_srq_o);
    c_hs_swap: cover property (@(posedge clk) disable iff (rst)
        bus_talk_oe_n == ENABLE_ON ##1 bus_listen_oe_n == ENABLE_ON);
endmodule // xcvr_dir

/* File: testbench/bus_ctrl_model.sv */
// Behavioural bus controller and far-end devices on the instrument bus
module bus_ctrl_model (
    // Clock
    input wire logic clk,
    // Device drive
    input wire logic [7:0] dev_data,
    input wire logic dev_data_oe_n,
    input wire logic [3:0] dev_hs,
    input wire logic dev_talk_oe_n,
    input wire logic dev_listen_oe_n,
    // Resolved lines: hs is eoi,dav,nrfd,ndac; ctl is ifc,ren,atn
    output logic [7:0] data_w,
    output logic [3:0] hs_w,
    output logic [2:0] ctl_w
);
    timeunit 1ns;
    timeprecision 1ns;
    // Arbitrary talk address of this controller
    localparam logic [7:0] TALK_ADDR = 8'h55;
    logic [7:0] my_data = 8'hFF;
    logic [3:0] my_hs = 4'hF;
    initial ctl_w = 3'b000;
    // no service request drive
    // Open-collector wiring with pull-ups: released lines read high, never stale
    assign data_w = (dev_data_oe_n ? 8'hFF : dev_data) & my_data;
    assign hs_w = {dev_talk_oe_n ? 2'b11 : dev_hs[3:2],
        dev_listen_oe_n ? 2'b11 : dev_hs[1:0]} & my_hs;
    task automatic put_data(input logic [7:0] v);
        @(negedge clk);
        ctl_w[0] = 1'b1;
        my_data = TALK_ADDR;
        repeat (4) @(negedge clk);
        ctl_w[0] = 1'b0;
        my_data = v;
    endtask
    task automatic set_hs(input logic [3:0] v);
        my_hs = v;
    endtask
    task automatic set_ctl(input logic [2:0] v);
        ctl_w = v;
    endtask
endmodule // bus_ctrl_model

/* File: testbench/xcvr_dir_tb_top.sv */
// Self-checking bench for the transceiver direction block
module xcvr_dir_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import xcvr_dir_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic data_line_direction_enable = 1'b0;
    logic handshake_direction_enable = 1'b0;
    logic serial_poll_hold = 1'b0;
    logic chip_srq_out = 1'b0;
    logic [7:0] chip_data_out = 8'h00;
    logic [3:0] chs = 4'h0;
    logic [7:0] chip_data_in, bus_data_i, bus_data_o;
    logic [3:0] hs_w;
    logic [2:0] ctl_w;
    logic chip_eoi_in, chip_dav_in, chip_nrfd_in, chip_ndac_in;
    logic chip_ifc_in, chip_ren_in, chip_atn_in, bus_srq_o, bus_srq_oe_n;
    logic bus_eoi_o, bus_dav_o, bus_nrfd_o, bus_ndac_o;
    logic bus_data_oe_n, bus_talk_oe_n, bus_listen_oe_n;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;

    xcvr_dir i_xcvr_dir (.clk, .rst, .data_line_direction_enable,
        .handshake_direction_enable, .serial_poll_hold, .chip_data_out, .chip_data_in,
        .chip_eoi_out(chs[3]), .chip_dav_out(chs[2]), .chip_nrfd_out(chs[1]),
        .chip_ndac_out(chs[0]), .chip_srq_out, .chip_eoi_in, .chip_dav_in, .chip_nrfd_in,
        .chip_ndac_in, .chip_ifc_in, .chip_ren_in, .chip_atn_in, .bus_data_i, .bus_data_o,
        .bus_data_oe_n, .bus_eoi_i(hs_w[3]), .bus_dav_i(hs_w[2]), .bus_nrfd_i(hs_w[1]),
        .bus_ndac_i(hs_w[0]), .bus_eoi_o, .bus_dav_o, .bus_nrfd_o, .bus_ndac_o,
        .bus_talk_oe_n, .bus_listen_oe_n, .bus_ifc_i(ctl_w[2]), .bus_ren_i(ctl_w[1]),
        .bus_atn_i(ctl_w[0]), .bus_srq_o, .bus_srq_oe_n);
    bus_ctrl_model i_bus_ctrl_model (.clk, .dev_data(bus_data_o), .dev_data_oe_n(bus_data_oe_n),
        .dev_hs({bus_eoi_o, bus_dav_o, bus_nrfd_o, bus_ndac_o}), .dev_talk_oe_n(bus_talk_oe_n),
        .dev_listen_oe_n(bus_listen_oe_n), .data_w(bus_data_i), .hs_w, .ctl_w);

    initial
    begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic chkb(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        chkb(nm, {7'h00, e}, {7'h00, g});
    endtask
    task automatic waitn(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic t_reset();
        chk1("data_oe_n", 1'b1, bus_data_oe_n);
        chk1("talk_oe_n", 1'b1, bus_talk_oe_n);
        chk1("listen_oe_n", 1'b1, bus_listen_oe_n);
        chk1("srq_oe_n", 1'b0, bus_srq_oe_n);
    endtask
    task automatic t_data();
        i_bus_ctrl_model.put_data(8'h3C);
        waitn(4);
        chkb("chip_data_in", 8'h3C, chip_data_in);
        chk1("data_oe_n", 1'b1, bus_data_oe_n);
        data_line_direction_enable = 1'b1;
        chip_data_out = 8'hA5;
        i_bus_ctrl_model.put_data(8'hC3);
        waitn(4);
        chk1("data_oe_n", 1'b0, bus_data_oe_n);
        chkb("bus_data_o", 8'hA5, bus_data_o);
        chkb("chip_data_in", 8'h3C, chip_data_in);
    endtask
    task automatic t_talk();
        handshake_direction_enable = 1'b1;
        chs = 4'hF;
        i_bus_ctrl_model.set_hs(4'h3);
        waitn(2);
        chk1("talk_oe_n", 1'b0, bus_talk_oe_n);
        chk1("listen_oe_n", 1'b1, bus_listen_oe_n);
        chkb("eoi_dav", 8'h03, {6'h00, bus_eoi_o, bus_dav_o});
        serial_poll_hold = 1'b1;
        waitn(2);
        chk1("dav_hold", 1'b0, bus_dav_o);
        chk1("chip_eoi_in", 1'b1, chip_eoi_in);
        chk1("chip_nrfd_in", 1'b1, chip_nrfd_in);
        serial_poll_hold = 1'b0;
        waitn(2);
        chk1("dav_free", 1'b1, bus_dav_o);
    endtask
    task automatic t_listen();
        handshake_direction_enable = 1'b0;
        i_bus_ctrl_model.set_hs(4'b0010);
        waitn(4);
        chk1("listen_oe_n", 1'b0, bus_listen_oe_n);
        chk1("talk_oe_n", 1'b1, bus_talk_oe_n);
        chk1("nrfd_o", 1'b1, bus_nrfd_o);
        chk1("chip_dav_in", 1'b0, chip_dav_in);
        chk1("ndac_o", 1'b1, bus_ndac_o);
        chk1("chip_eoi_in", 1'b0, chip_eoi_in);
        chk1("chip_ndac_in", 1'b1, chip_ndac_in);
    endtask
    task automatic t_ctl();
        i_bus_ctrl_model.set_ctl(3'b101);
        chip_srq_out = 1'b1;
        waitn(4);
        chkb("ifc_ren_atn", 8'h05, {5'h00, chip_ifc_in, chip_ren_in, chip_atn_in});
        chk1("srq_o", 1'b1, bus_srq_o);
        chk1("srq_oe_n", 1'b0, bus_srq_oe_n);
    endtask

    initial
    begin
        waitn(6);
        rst = 1'b0;
        t_reset();
        t_data();
        t_talk();
        t_listen();
        t_ctl();
        wrap_up();
    end
endmodule // xcvr_dir_tb_top
